// [acsr_host_model.sv]
/*
 * Host-side partner: drives setup word writes and the shared conversion pin.
 * Assumes acsr_pkg is compiled first and that the bench calls its tasks.
 */
`timescale 1ns/1ps
`default_nettype none

module acsr_host_model (
    // Clock.
    input  wire logic                sys_clk,
    // Bus and conversion pin toward the device.
    output var  acsr_pkg::acsr_wr_t  bus_wr,
    output var  logic                conversion_clock_in
);
    import acsr_pkg::*;

    // ****************************************************************
    // Idle levels and transfers
    // ****************************************************************

    // The bus starts idle and the pin rests high outside pulses.
    initial begin
        bus_wr              = '0;
        conversion_clock_in = 1'b1;
    end

    // One write, held for a single edge; select 00 picks the word.
    task automatic put_word(input logic [1:0] sel, input logic [9:0] d);
        @(posedge sys_clk);
        bus_wr <= {1'b1, sel[0], sel[1], d};
        @(posedge sys_clk);
        bus_wr <= {1'b0, ~sel[0], ~sel[1], ~d}; // Released lines show junk.
    endtask : put_word

    // One low pulse of the shared pin, then idle high for a while.
    task automatic pin_fall(input int lo, input int hi);
        @(posedge sys_clk);
        conversion_clock_in <= 1'b0;
        repeat (lo) @(posedge sys_clk);
        conversion_clock_in <= 1'b1;
        repeat (hi) @(posedge sys_clk);
    endtask : pin_fall

endmodule : acsr_host_model

`default_nettype wire

// [acsr_params.svh]
/*
 * Constants of the conversion setup word: select code, field positions,
 * reset value and the internal conversion divider.
 * Assumes it is included by bare name from the package and the top module.
 */
`ifndef ACSR_PARAMS_SVH
`define ACSR_PARAMS_SVH

// ****************************************************************
// Select code and layout
// ****************************************************************
`define ACSR_SEL_SETUP    2'h0
`define ACSR_WORD_W       10
`define ACSR_RESET_VALUE  10'h020
`define ACSR_BIT_EXT_REF  0
`define ACSR_BIT_MODE     1
`define ACSR_BIT_SLEEP    2
`define ACSR_BIT_CH_LO    3
`define ACSR_BIT_CH_HI    7
`define ACSR_BIT_TEST_LO  8
`define ACSR_BIT_TEST_HI  9

// ****************************************************************
// Timing
// ****************************************************************
`define ACSR_CONV_DIV     33

`endif

// [acsr_pkg.sv]
/*
 * Types of the conversion setup block.
 * Assumes acsr_params.svh sits in the same folder.
 */
`include "acsr_params.svh"

package acsr_pkg;

    // Source routed into the converter for one result.
    typedef enum logic [2:0] {
        SRC_A_POS,
        SRC_A_NEG,
        SRC_B_POS,
        SRC_B_NEG,
        SRC_PAIR_A,
        SRC_PAIR_B,
        SRC_UPPER,
        SRC_MID
    } acsr_src_t;

    // Register write from the parallel bus.
    typedef struct packed {
        logic                      strobe;
        logic                      reg_select_lo;
        logic                      reg_select_hi;
        logic [`ACSR_WORD_W-1:0]   data;
    } acsr_wr_t;

    // Control outputs toward the analog core and the result store.
    typedef struct packed {
        logic      ext_ref;
        logic      sleep_request;
        logic      hold;
        logic      result_write;
        logic      lower_level;
        acsr_src_t source;
    } acsr_ctrl_t;

endpackage : acsr_pkg

// [acsr_top.sv]
/*
 * Conversion setup word of a four-input sampling converter, with the
 * conversion sequencer and the block-ready output that it steers.
 * Assumes the bus strobe, select lines and the conversion clock pin are
 * synchronous to sys_clk, and that the trigger level comes from elsewhere.
 */
`timescale 1ns/1ps
`default_nettype none
`include "acsr_params.svh"

module acsr_top #(
    parameter int TRIG_W   = 5,
    parameter int CONV_DIV = `ACSR_CONV_DIV
) (
    // Clock and reset.
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Parallel bus write of the setup word.
    input  wire acsr_pkg::acsr_wr_t bus_wr,
    // Conversion clock or active-low start, shared pin.
    input  wire logic              conversion_clock_in,
    // Results per block, from the second setup word.
    input  wire logic [TRIG_W-1:0] trigger_level,
    // Controls to the analog core and the result store.
    output var  acsr_pkg::acsr_ctrl_t ctrl,
    // Block of results ready, active low one-cycle pulse.
    output logic                   block_ready_n
);
    import acsr_pkg::*;

    typedef enum logic [0:0] {ST_IDLE, ST_RUN} acsr_state_t;

    // ****************************************************************
    // Sequence decode
    // ****************************************************************

    // Last slot index of the sequence picked by bits 7:3.
    function automatic logic [1:0] acsr_last(input logic [4:0] code);
        case (code)
            5'h11, 5'h15, 5'h19: acsr_last = 2'h1;
            5'h12, 5'h16:        acsr_last = 2'h2;
            5'h13:               acsr_last = 2'h3;
            default:             acsr_last = 2'h0;
        endcase
    endfunction : acsr_last

    // Source converted in one slot; reserved codes fall back to input A+.
    function automatic acsr_src_t acsr_slot(input logic [4:0] code,
                                            input logic [1:0] idx);
        acsr_src_t s;
        s = SRC_A_POS;
        case (code)
            5'h00, 5'h01, 5'h02, 5'h03: s = acsr_src_t'({1'b0, code[1:0]});
            5'h04:                      s = SRC_PAIR_A;
            5'h05:                      s = SRC_PAIR_B;
            5'h11, 5'h12, 5'h13:        s = acsr_src_t'({1'b0, idx});
            5'h15:                      s = (idx == 2'h0) ? SRC_A_POS
                                                          : SRC_PAIR_B;
            5'h16:                      s = (idx == 2'h2) ? SRC_PAIR_B
                                          : acsr_src_t'({1'b0, idx});
            5'h19:                      s = (idx == 2'h0) ? SRC_PAIR_A
                                                          : SRC_PAIR_B;
            default:                    s = SRC_A_POS;
        endcase
        return s;
    endfunction : acsr_slot

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta_n;
    logic rst_sync_n;

    // Two flops release the asynchronous reset in step with sys_clk.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ****************************************************************
    // Setup word
    // ****************************************************************
    logic [`ACSR_WORD_W-1:0] cfg;
    wire  sel_setup = bus_wr.strobe &&
        ({bus_wr.reg_select_hi, bus_wr.reg_select_lo} == `ACSR_SEL_SETUP);

    // Only the all-low select code loads the word, even in power down.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cfg <= `ACSR_RESET_VALUE;
        end else if (sel_setup) begin
            cfg <= bus_wr.data;
        end
    end

    // Field views of the word.
    wire       cfg_ext_ref = cfg[`ACSR_BIT_EXT_REF];
    wire       cfg_single  = cfg[`ACSR_BIT_MODE];
    wire       cfg_sleep   = cfg[`ACSR_BIT_SLEEP];
    wire [4:0] cfg_chan    = cfg[`ACSR_BIT_CH_HI:`ACSR_BIT_CH_LO];
    wire [1:0] cfg_test    = cfg[`ACSR_BIT_TEST_HI:`ACSR_BIT_TEST_LO];
    wire [1:0] seq_last    = acsr_last(cfg_chan);

    // ****************************************************************
    // Pin edge and internal conversion tick
    // ****************************************************************
    logic        pin_prev;
    logic [5:0]  div_cnt;
    wire         pin_fall = pin_prev && !conversion_clock_in;
    wire         div_end  = (div_cnt == 6'(CONV_DIV - 1));

    // Edge history of the pin and the divider that paces single scans.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_prev <= 1'b1;
            div_cnt  <= 6'h00;
        end else begin
            pin_prev <= conversion_clock_in;
            div_cnt  <= div_end ? 6'h00 : div_cnt + 6'h01;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    acsr_state_t state;
    acsr_state_t next_state;
    logic [1:0]  idx;
    logic [1:0]  next_idx;
    logic        next_write;
    logic        next_hold;

    // Picks when a result is written and which slot comes next.
    always_comb begin
        next_state = state;
        next_idx   = idx;
        next_write = 1'b0;
        next_hold  = 1'b0;
        case (state)
            ST_IDLE: begin
                if (cfg_sleep) begin
                    next_idx = idx;
                end else if (!cfg_single && pin_fall) begin
                    next_hold  = 1'b1;
                    next_write = 1'b1;
                    next_idx   = (idx >= seq_last) ? 2'h0 : idx + 2'h1;
                end else if (cfg_single && pin_fall) begin
                    next_hold  = 1'b1;
                    next_idx   = 2'h0;
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (cfg_sleep) begin
                    next_state = ST_IDLE;
                    next_idx   = 2'h0;
                end else if (div_end) begin
                    next_write = 1'b1;
                    if (idx >= seq_last) begin
                        next_idx   = 2'h0;
                        next_state = ST_IDLE;
                    end else begin
                        next_idx = idx + 2'h1;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_idx   = 2'h0;
            end
        endcase
    end

    // A setup write restarts the scan order at its first slot.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= ST_IDLE;
            idx   <= 2'h0;
        end else begin
            state <= sel_setup ? ST_IDLE : next_state;
            idx   <= sel_setup ? 2'h0 : next_idx;
        end
    end

    // ****************************************************************
    // Source routing
    // ****************************************************************
    acsr_src_t chan_src;
    acsr_src_t next_src;
    wire       next_lower = (cfg_test == 2'h3);

    // Check levels replace the inputs whenever a check code is set.
    always_comb begin
        chan_src = acsr_slot(cfg_chan, idx);
        case (cfg_test)
            2'h1:    next_src = SRC_UPPER;
            2'h2:    next_src = SRC_MID;
            2'h3:    next_src = SRC_A_POS;
            default: next_src = chan_src;
        endcase
    end

    // ****************************************************************
    // Outputs and block counting
    // ****************************************************************
    logic [TRIG_W-1:0] wr_cnt;
    wire  [TRIG_W-1:0] cnt_inc  = wr_cnt + TRIG_W'(1);
    wire               trig_hit = next_write && (cnt_inc >= trigger_level);

    // All outputs leave flops; ready pulses once per completed block.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl          <= '0;
            block_ready_n <= 1'b1;
            wr_cnt        <= '0;
        end else begin
            ctrl.ext_ref       <= cfg_ext_ref;
            ctrl.sleep_request <= cfg_sleep;
            ctrl.hold          <= next_hold;
            ctrl.result_write  <= next_write;
            ctrl.lower_level   <= next_lower;
            ctrl.source        <= next_src;
            if (cfg_test != 2'h0) begin
                block_ready_n <= 1'b1;
                wr_cnt        <= '0;
            end else if (trig_hit) begin
                block_ready_n <= 1'b0;
                wr_cnt        <= '0;
            end else begin
                block_ready_n <= 1'b1;
                wr_cnt        <= next_write ? cnt_inc : wr_cnt;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_reset_word: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_sync_n) |-> cfg == `ACSR_RESET_VALUE)
        else $error("Setup word not at reset value after release.");

    chk_word_store: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        sel_setup |=> cfg == $past(bus_wr.data))
        else $error("Setup word did not take the written data.");

    chk_other_select: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        bus_wr.strobe && !sel_setup |=> $stable(cfg))
        else $error("Setup word changed on another select code.");

    chk_cont_write: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        !cfg_single && !cfg_sleep && state == ST_IDLE && pin_fall
            && !sel_setup |=> ctrl.result_write && ctrl.hold)
        else $error("Falling clock edge wrote no result.");

    chk_start_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        cfg_single && !cfg_sleep && state == ST_IDLE && pin_fall
            && !sel_setup |=> ctrl.hold ##0 !ctrl.result_write)
        else $error("Start edge did not hold the inputs.");

    chk_sleep_quiet: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        cfg_sleep |=> !ctrl.result_write && !ctrl.hold)
        else $error("Result written while powered down.");

    chk_check_ready: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        cfg_test != 2'h0 |=> block_ready_n)
        else $error("Ready asserted in check mode.");

    chk_ready_pulse: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        !block_ready_n |-> ctrl.result_write ##1 block_ready_n)
        else $error("Ready pulse not tied to a single write.");

    chk_upper_route: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        cfg_test == 2'h1 |=> ctrl.source == SRC_UPPER)
        else $error("Upper check level not routed.");

endmodule : acsr_top

`default_nettype wire

// [acsr_top_test.sv]
/*
 * Self-checking bench of the setup word block with a result model.
 * Assumes acsr_pkg, acsr_top and acsr_host_model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module acsr_top_test;
    import acsr_pkg::*;

    logic        sys_clk       = 1'b0;
    logic        rst_n         = 1'b0;
    logic [4:0]  trigger_level = 5'h01;
    acsr_wr_t    bus_wr;
    logic        conversion_clock_in;
    acsr_ctrl_t  ctrl;
    logic        block_ready_n;
    logic [9:0]  m_cfg         = 10'h020;
    logic [15:0] plan;
    logic [15:0] g;
    logic [15:0] e;
    acsr_src_t   exp_src;
    int          slot, cnt, eff, n_wr, n_hold, fail_count, checked;
    int          seed          = 99345;
    bit          run           = 1'b0;
    bit          chk_rdy       = 1'b0;
    logic [4:0]  codes [13]    = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
                                   5'h05, 5'h06, 5'h11, 5'h12, 5'h13,
                                   5'h15, 5'h16, 5'h19};

    acsr_top #(.TRIG_W(5), .CONV_DIV(4)) u_acsr_top (
        .sys_clk             (sys_clk),
        .rst_n               (rst_n),
        .bus_wr              (bus_wr),
        .conversion_clock_in (conversion_clock_in),
        .trigger_level       (trigger_level),
        .ctrl                (ctrl),
        .block_ready_n       (block_ready_n)
    );

    acsr_host_model u_acsr_host_model (
        .sys_clk             (sys_clk),
        .bus_wr              (bus_wr),
        .conversion_clock_in (conversion_clock_in)
    );

    // Free-running 200 MHz clock.
    always #2.5 sys_clk = ~sys_clk;

    // ****************************************************************
    // Model and helpers
    // ****************************************************************

    // Slot order of a channel code: length, then four 3-bit sources.
    function automatic logic [15:0] plan_of(input logic [4:0] c);
        case (c)
            5'h01:   plan_of = 16'h1001;
            5'h02:   plan_of = 16'h1002;
            5'h03:   plan_of = 16'h1003;
            5'h04:   plan_of = 16'h1004;
            5'h05:   plan_of = 16'h1005;
            5'h11:   plan_of = 16'h2008;
            5'h12:   plan_of = 16'h3088;
            5'h13:   plan_of = 16'h4688;
            5'h15:   plan_of = 16'h2028;
            5'h16:   plan_of = 16'h3148;
            5'h19:   plan_of = 16'h202c;
            default: plan_of = 16'h1000;
        endcase
    endfunction : plan_of

    // Counts one comparison and reports a mismatch at once.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t ns: got %h expected %h",
                     $time, got, exp);
        end
    endtask : check

    // Writes through the host and mirrors an accepted word in the model.
    task automatic wr(input logic [1:0] sel, input logic [9:0] d);
        u_acsr_host_model.put_word(sel, d);
        if (sel == 2'b00) begin
            m_cfg = d;
            slot  = 0;
        end
    endtask : wr

    // Gives n falling edges and compares the number of results.
    task automatic edges(input int n, input int want);
        n_wr = 0;
        repeat (n) u_acsr_host_model.pin_fall(1, 1);
        repeat (3) @(posedge sys_clk);
        check(16'(n_wr), 16'(want));
    endtask : edges

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    // Check results need no ready pulse, so every write is compared.
    always @(negedge sys_clk) begin
        if (run) begin
            if (ctrl.hold === 1'b1) n_hold++;
            if (ctrl.result_write === 1'b1) begin
                n_wr++;
                plan    = plan_of(m_cfg[7:3]);
                exp_src = acsr_src_t'(plan[slot*3 +: 3]);
                if (m_cfg[9:8] == 2'b01) exp_src = SRC_UPPER;
                if (m_cfg[9:8] == 2'b10) exp_src = SRC_MID;
                if (m_cfg[9:8] == 2'b11) exp_src = SRC_A_POS;
                g = 16'({ctrl.lower_level, ctrl.source});
                e = 16'({m_cfg[9:8] == 2'b11, exp_src});
                check(g, e); // Routed source.
                slot = (slot + 1) % int'(plan[15:12]);
                cnt  = (m_cfg[9:8] != 2'b00) ? 0 : cnt + 1;
                if (chk_rdy) check(16'(block_ready_n), 16'(cnt < eff));
                if (cnt >= eff) cnt = 0;
            end
            if (ctrl.result_write !== 1'b1 || m_cfg[9:8] != 2'b00)
                check(16'(block_ready_n), 16'h0001); // Quiet.
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************

    // Main sequence.
    initial begin
        int n;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        check(16'(ctrl), 16'h0004); // Idle controls, pair A.
        run = 1'b1;
        edges(2, 2); // Pair source from reset word.
        for (int s = 1; s < 4; s++) wr(2'(s), 10'h3ff);
        edges(2, 2); // Other selects ignored.
        foreach (codes[i]) begin
            wr(2'b00, {2'b00, codes[i], 3'b000});
            n = 2 * int'(plan_of(codes[i]) >> 12) + $unsigned($random(seed)) % 3;
            edges(n, n); // Results per edge.
        end
        for (int t = 1; t < 4; t++) begin
            @(posedge sys_clk);
            trigger_level <= 5'($unsigned($random(seed)) % 9);
            wr(2'b00, {2'(t), 5'h13, 3'b000});
            edges(3, 3); // Check levels.
            wr(2'b00, 10'h098); // Full init again.
            eff = (trigger_level == 5'h00) ? 1 : int'(trigger_level);
            chk_rdy = 1'b1;
            edges(2 * eff + 1, 2 * eff + 1); // Block pulses.
            chk_rdy = 1'b0;
        end
        wr(2'b00, 10'h09a);
        repeat (2) begin
            n_hold = 0;
            n_wr   = 0;
            u_acsr_host_model.pin_fall(1, 2);
            u_acsr_host_model.pin_fall(1, 1);
            repeat (30) @(posedge sys_clk);
            check(16'(n_hold), 16'h0001); // One hold per start.
            check(16'(n_wr), 16'h0004); // One scan per start.
        end
        wr(2'b00, 10'h004);
        edges(4, 0); // No results asleep.
        @(negedge sys_clk);
        check(16'({ctrl.ext_ref, ctrl.sleep_request}), 16'h0001);
        wr(2'b00, 10'h005);
        repeat (2) @(negedge sys_clk);
        check(16'({ctrl.ext_ref, ctrl.sleep_request}), 16'h0003);
        wr(2'b00, 10'h001);
        edges(3, 3); // Awake again.
        test_done();
    end

    // Cuts a hang short well past the expected run length.
    initial begin
        #200000;
        fail_count++;
        test_done();
    end

endmodule : acsr_top_test

`default_nettype wire
